//--- srp_read_path.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - device acks valid address byte next cycle
// - type 1010 array, 1011 extra spaces
// - reads ignore both write protections
// - current read uses counter, then increments it
// - array counter wraps last byte to zero
// - id and serial accesses load shared counter
// - keep sending bytes while master acks
// - identification_page: 00 space, low four bits
// - identification_page reads wrap inside the page
// - lock check: ack data if page unlocked
// - start resets logic, stop returns standby
// - protect read uses space bits 11
// - protect byte: zeros above, protect bit low
// - further protect bytes repeat same value
// - serial read: 10 space, low four bits
// - serial number cannot be written
// - serial reads wrap after sixteen bytes
// - protect bit one makes array read-only
module srp_read_path
	import srp_pkg::*;
#(
	parameter int ARRAY_BYTES = 2048,
	parameter int PAGE_BYTES = 16,
	// arbitrary value, stands in for the factory contents
	parameter logic [127:0] SERIAL_NUMBER = 128'h5a3c_96e1_0f2d_7b48_c3a5_1e69_d2f0_874b
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OEN,
	input wire logic SOFT_PROTECT_BIT,
	input wire logic IDENTIFICATION_PAGE_LOCKED,
	input wire logic LOAD_WE,
	input wire logic LOAD_IDPAGE,
	input wire logic [ADDR_W-1:0] LOAD_ADDR,
	input wire logic [7:0] LOAD_DATA,
	output logic [ADDR_W-1:0] ADDR_COUNT,
	output logic READ_BUSY
);

	srp_bus_ev_t ev;
	srp_state_t state_q;
	srp_rx_t kind_q;
	srp_area_t area_q;
	logic [3:0] cnt_q;
	logic [7:0] rx_q;
	logic [7:0] dev_q;
	logic [7:0] tx_q;
	logic mack_q;
	logic [ADDR_W-1:0] addr_q;
	logic sda_oen_q;
	logic busy_q;
	logic byte_in;
	logic ack_ok;
	logic load_now;
	logic [7:0] rd_byte;
	logic [3:0] dev_type;
	logic dev_read;

	logic [7:0] array_mem [0:ARRAY_BYTES-1];
	logic [7:0] id_mem [0:PAGE_BYTES-1];

	function automatic logic [ADDR_W-1:0] next_addr(input srp_area_t area, input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] n;
		n = a;
		case (area)
			AR_ARRAY: n = a + 11'h001;
			AR_IDPAGE: n = {a[ADDR_W-1:BLOCK_W], a[BLOCK_W-1:0] + 4'h1};
			AR_SERIAL: n = {a[ADDR_W-1:BLOCK_W], a[BLOCK_W-1:0] + 4'h1};
			default: n = a;
		endcase
		return n;
	endfunction

	srp_pin_sync u_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.scl_pin(SCL),
		.sda_pin(SDA_IN),
		.ev(ev)
	);

	assign dev_type = dev_q[DEV_TYPE_MSB:DEV_TYPE_LSB];
	assign dev_read = dev_q[DEV_RW_POS];
	assign byte_in = ev.scl_fall && state_q == ST_RX && cnt_q == 4'(BITS_PER_BYTE);

	// acknowledge decision for the byte just received
	always_comb begin
		ack_ok = 1'b0;
		case (kind_q)
			RX_DEV: ack_ok = rx_q[DEV_TYPE_MSB:DEV_TYPE_LSB] == TYPE_ARRAY
				|| rx_q[DEV_TYPE_MSB:DEV_TYPE_LSB] == TYPE_EXTRA;
			RX_WORD: ack_ok = 1'b1;
			RX_DATA: ack_ok = dev_type == TYPE_EXTRA && area_q == AR_IDPAGE && !IDENTIFICATION_PAGE_LOCKED;
			default: ack_ok = 1'b0;
		endcase
	end

	// a read is served whatever the protect bit or the page lock say
	always_comb begin
		case (area_q)
			AR_ARRAY: rd_byte = array_mem[addr_q];
			AR_IDPAGE: rd_byte = id_mem[addr_q[BLOCK_W-1:0]];
			AR_SERIAL: rd_byte = SERIAL_NUMBER[8'(127 - 8 * int'(addr_q[BLOCK_W-1:0])) -: 8];
			default: rd_byte = {7'h00, SOFT_PROTECT_BIT};
		endcase
	end

	assign load_now = ev.scl_fall && ((state_q == ST_ACK && kind_q == RX_DEV && dev_read)
		|| (state_q == ST_MACK && !mack_q));

	// protocol sequencing; start always wins and restarts reception
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= ST_IDLE;
			kind_q <= RX_DEV;
			cnt_q <= CNT_RST;
		end else if (ev.start) begin
			state_q <= ST_RX;
			kind_q <= RX_DEV;
			cnt_q <= CNT_RST;
		end else if (ev.stop) begin
			state_q <= ST_IDLE;
			cnt_q <= CNT_RST;
		end else begin
			case (state_q)
				ST_RX: begin
					if (ev.scl_rise) begin
						cnt_q <= cnt_q + 4'h1;
					end else if (byte_in) begin
						cnt_q <= CNT_RST;
						state_q <= ack_ok ? ST_ACK : ST_IDLE;
					end
				end
				ST_ACK: begin
					if (ev.scl_fall) begin
						cnt_q <= CNT_RST;
						case (kind_q)
							RX_DEV: begin
								if (dev_read) begin
									state_q <= ST_TX;
								end else begin
									state_q <= ST_RX;
									kind_q <= RX_WORD;
								end
							end
							RX_WORD: begin
								state_q <= ST_RX;
								kind_q <= RX_DATA;
							end
							// only the one-byte lock check is taken; writes belong elsewhere
							default: state_q <= ST_IDLE;
						endcase
					end
				end
				ST_TX: begin
					if (ev.scl_fall) begin
						if (cnt_q == LAST_TX_BIT) begin
							state_q <= ST_MACK;
							cnt_q <= CNT_RST;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (ev.scl_fall) begin
						state_q <= mack_q ? ST_IDLE : ST_TX;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// incoming bits are taken on the rising edge of the bus clock
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_q <= SHIFT_RST;
			mack_q <= 1'b1;
		end else if (ev.scl_rise) begin
			if (state_q == ST_RX) begin
				rx_q <= {rx_q[6:0], ev.sda};
			end
			if (state_q == ST_MACK) begin
				mack_q <= ev.sda;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			dev_q <= SHIFT_RST;
		end else if (byte_in && kind_q == RX_DEV) begin
			dev_q <= rx_q;
		end
	end

	// the outgoing byte shifts on falling edges, msb first
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_q <= SHIFT_RST;
		end else if (load_now) begin
			tx_q <= rd_byte;
		end else if (ev.scl_fall && state_q == ST_TX) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	// data line: low for ack, follows tx bits, released otherwise
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			sda_oen_q <= 1'b1;
		end else if (ev.start || ev.stop) begin
			sda_oen_q <= 1'b1;
		end else if (byte_in) begin
			sda_oen_q <= !ack_ok;
		end else if (load_now) begin
			sda_oen_q <= rd_byte[7];
		end else if (ev.scl_fall && state_q == ST_TX) begin
			sda_oen_q <= (cnt_q == LAST_TX_BIT) ? 1'b1 : tx_q[6];
		end else if (ev.scl_fall && state_q != ST_TX) begin
			sda_oen_q <= 1'b1;
		end
	end

	// shared address counter and the space it points into
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			addr_q <= ADDR_RST;
			area_q <= AR_ARRAY;
		end else if (byte_in && ack_ok && kind_q == RX_DEV) begin
			if (rx_q[DEV_TYPE_MSB:DEV_TYPE_LSB] == TYPE_ARRAY) begin
				area_q <= AR_ARRAY;
			end
		end else if (byte_in && kind_q == RX_WORD) begin
			if (dev_type == TYPE_ARRAY) begin
				addr_q <= {dev_q[DEV_SEL_MSB:DEV_SEL_LSB], rx_q};
				area_q <= AR_ARRAY;
			end else begin
				case (rx_q[WORD_SPACE_MSB:WORD_SPACE_LSB])
					SEL_IDPAGE: begin
						addr_q <= {7'h00, rx_q[WORD_BYTE_MSB:0]};
						area_q <= AR_IDPAGE;
					end
					SEL_SERIAL: begin
						addr_q <= {7'h00, rx_q[WORD_BYTE_MSB:0]};
						area_q <= AR_SERIAL;
					end
					SEL_PROTECT: area_q <= AR_PROTECT;
					// lock check works on the identification_page
					default: area_q <= AR_IDPAGE;
				endcase
			end
		end else if (load_now) begin
			addr_q <= next_addr(area_q, addr_q);
		end
	end

	// contents come from the write side; the serial block has no load path
	always_ff @(posedge MCLK) begin
		if (LOAD_WE && !SOFT_PROTECT_BIT) begin
			if (LOAD_IDPAGE) begin
				if (!IDENTIFICATION_PAGE_LOCKED) begin
					id_mem[LOAD_ADDR[BLOCK_W-1:0]] <= LOAD_DATA;
				end
			end else begin
				array_mem[LOAD_ADDR] <= LOAD_DATA;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= state_q != ST_IDLE;
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			SDA_OUT <= 1'b0;
		end else begin
			SDA_OUT <= 1'b0;
		end
	end

	assign SDA_OEN = sda_oen_q;
	assign ADDR_COUNT = addr_q;
	assign READ_BUSY = busy_q;

endmodule
`default_nettype wire

//--- srp_pkg.sv
package srp_pkg;

	localparam int ADDR_W = 11;
	localparam int BLOCK_W = 4;

	// device type nibbles of the address byte
	localparam logic [3:0] TYPE_ARRAY = 4'ha;
	localparam logic [3:0] TYPE_EXTRA = 4'hb;

	// space_select_bits codes in the word address of a type-extra access
	localparam logic [1:0] SEL_IDPAGE = 2'h0;
	localparam logic [1:0] SEL_LOCK = 2'h1;
	localparam logic [1:0] SEL_SERIAL = 2'h2;
	localparam logic [1:0] SEL_PROTECT = 2'h3;

	// field positions inside the device address byte
	localparam int DEV_TYPE_MSB = 7;
	localparam int DEV_TYPE_LSB = 4;
	localparam int DEV_SEL_MSB = 3;
	localparam int DEV_SEL_LSB = 1;
	localparam int DEV_RW_POS = 0;

	// field positions inside the word address byte
	localparam int WORD_SPACE_MSB = 7;
	localparam int WORD_SPACE_LSB = 6;
	localparam int WORD_BYTE_MSB = 3;

	localparam int BITS_PER_BYTE = 8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [3:0] CNT_RST = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_MACK
	} srp_state_t;

	typedef enum logic [1:0] {
		RX_DEV,
		RX_WORD,
		RX_DATA
	} srp_rx_t;

	typedef enum logic [1:0] {
		AR_ARRAY,
		AR_IDPAGE,
		AR_SERIAL,
		AR_PROTECT
	} srp_area_t;

	// conditions seen on the bus, one clock pulse each except sda
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} srp_bus_ev_t;

endpackage

//--- srp_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module srp_pin_sync
	import srp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output srp_bus_ev_t ev
);

	logic scl_m;
	logic scl_s;
	logic scl_p;
	logic sda_m;
	logic sda_s;
	logic sda_p;

	// both pins go through the same three stages so start and stop keep their order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_m <= scl_pin;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= sda_pin;
			sda_s <= sda_m;
			sda_p <= sda_s;
		end
	end

	always_comb begin
		ev.scl_rise = scl_s & ~scl_p;
		ev.scl_fall = ~scl_s & scl_p;
		ev.start = scl_s & scl_p & sda_p & ~sda_s;
		ev.stop = scl_s & scl_p & ~sda_p & sda_s;
		ev.sda = sda_s;
	end

endmodule
`default_nettype wire

//--- srp_properties.sv
`timescale 1ns/100ps
`default_nettype none
module srp_properties
	import srp_pkg::*;
(
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic SCL,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OEN,
	input wire logic LOAD_WE,
	input wire logic [ADDR_W-1:0] ADDR_COUNT,
	input wire logic READ_BUSY
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);
	sda_low_a: assert property (SDA_OUT == 1'b0) else $error("sda high");
	reset_idle_a: assert property ($rose(RSTN) |-> SDA_OEN && !READ_BUSY && ADDR_COUNT == 11'h000)
		else $error("reset state");
	idle_free_a: assert property (!READ_BUSY && !$past(READ_BUSY) |-> SDA_OEN) else $error("idle drive");
	// back-door stores belong to the write path and leave the counter alone; cycles after one are skipped
	count_hold_a: assert property (!READ_BUSY && !$past(READ_BUSY) && !$past(LOAD_WE) |-> $stable(ADDR_COUNT))
		else $error("counter moved");
	drive_busy_a: assert property (!SDA_OEN |-> $past(READ_BUSY)) else $error("drive when idle");
	end_free_a: assert property ($fell(READ_BUSY) |-> SDA_OEN) else $error("held at end");
	start_low_a: assert property ($rose(READ_BUSY) |-> !SDA_IN) else $error("busy without start");
	change_low_a: assert property ($changed(SDA_OEN) && $past(READ_BUSY) |-> !$past(SCL, 2))
		else $error("sda moved scl high");
	cover property ($rose(READ_BUSY));
	cover property ($past(ADDR_COUNT) == 11'h7ff && ADDR_COUNT == 11'h000);
	cover property ($fell(SDA_OEN));
endmodule
bind srp_read_path srp_properties i_props (.MCLK(MCLK), .RSTN(RSTN), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
	.SDA_OEN(SDA_OEN), .LOAD_WE(LOAD_WE), .ADDR_COUNT(ADDR_COUNT), .READ_BUSY(READ_BUSY));
`default_nettype wire

//--- srp_master.sv
`timescale 1ns/100ps
`default_nettype none
module srp_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_o
);
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// start waits out a late ack release, holds sda low a full period for the pin sampler
	task automatic start();
		w(5);
		sda_o <= 1'b1;
		w(2);
		scl <= 1'b1;
		w(4);
		sda_o <= 1'b0;
		w(8);
		scl <= 1'b0;
	endtask
	task automatic stop();
		w(5);
		sda_o <= 1'b0;
		w(2);
		scl <= 1'b1;
		w(4);
		sda_o <= 1'b1;
		w(4);
	endtask
	// 80 ns bit, low 5 high 3; sampled mid-high, clear of the device's late change
	task automatic bitx(input logic b, output logic r);
		w(1);
		sda_o <= b;
		w(4);
		scl <= 1'b1;
		w(2);
		r = sda;
		w(1);
		scl <= 1'b0;
	endtask
	task automatic wr8(input logic [7:0] b, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(b[i], r);
		end
		bitx(1'b1, nak);
	endtask
	task automatic rd8(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, d[i]);
		end
		bitx(last, r);
	endtask
endmodule
`default_nettype wire

//--- srp_read_path_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module srp_read_path_tb_top
	import srp_pkg::*;
;
	// arbitrary value standing in for the factory number
	localparam logic [127:0] SN = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
	logic mclk, rstn, prot, locked, we, wid, nak, scl, sda_o, sda_oen, sda_out, busy;
	logic [ADDR_W-1:0] la, cnt;
	logic [7:0] ld;
	logic [7:0] got [0:16];
	wire logic sda;
	int failures = 0, n_tests = 0, cyc = 0;
	// open-drain line with pull-up
	assign sda = sda_o & (sda_oen | sda_out);
	srp_read_path #(.SERIAL_NUMBER(SN)) i_dut (.MCLK(mclk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OEN(sda_oen), .SOFT_PROTECT_BIT(prot), .IDENTIFICATION_PAGE_LOCKED(locked), .LOAD_WE(we),
		.LOAD_IDPAGE(wid), .LOAD_ADDR(la), .LOAD_DATA(ld), .ADDR_COUNT(cnt), .READ_BUSY(busy));
	srp_master i_mst (.clk(mclk), .sda(sda), .scl(scl), .sda_o(sda_o));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	function automatic logic [7:0] fa(input logic [10:0] a);
		return a[7:0] ^ {a[10:8], 5'h0b};
	endfunction
	function automatic logic [7:0] fi(input logic [3:0] a);
		return {4'hc, a} ^ 8'h03;
	endfunction
	task automatic chk(input string nm, input logic [10:0] s, input logic [10:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_sim();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// rnd adds the dummy write that sets the word address; n bytes land in got
	task automatic rd(input logic [3:0] ty, input logic [2:0] s, input logic rnd, input logic [7:0] wa, input int n);
		logic a;
		if (rnd) begin
			i_mst.start();
			i_mst.wr8({ty, s, 1'b0}, a);
			chk("wr ack", {10'h0, a}, 11'h000);
			i_mst.wr8(wa, a);
			chk("word ack", {10'h0, a}, 11'h000);
		end
		i_mst.start();
		i_mst.wr8({ty, s, 1'b1}, a);
		chk("rd ack", {10'h0, a}, 11'h000);
		for (int i = 0; i < n; i++) begin
			i_mst.rd8(i == n - 1, got[i]);
		end
		i_mst.stop();
		chk("released", {10'h0, sda_oen}, 11'h001);
	endtask
	task automatic wr3(input logic [7:0] wa, input logic [7:0] d);
		i_mst.start();
		i_mst.wr8({TYPE_EXTRA, 3'h0, 1'b0}, nak);
		i_mst.wr8(wa, nak);
		i_mst.wr8(d, nak);
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		{rstn, prot, locked, we, wid} = 5'h00;
		la = 11'h000;
		ld = 8'h00;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		we <= 1'b1;
		for (int i = 0; i < 2064; i++) begin
			wid <= i >= 2048;
			la <= 11'(i);
			ld <= (i >= 2048) ? fi(4'(i)) : fa(11'(i));
			@(posedge mclk);
		end
		// protected store must be dropped, id byte 0 keeps its value
		prot <= 1'b1;
		la <= 11'h000;
		@(posedge mclk);
		we <= 1'b0;
		rd(TYPE_ARRAY, 3'h7, 1'b1, 8'hfe, 3);
		for (int i = 0; i < 3; i++) begin
			chk("array", {3'h0, got[i]}, {3'h0, fa(11'h7fe + 11'(i))});
		end
		chk("count", cnt, 11'h001);
		rd(TYPE_ARRAY, 3'h0, 1'b0, 8'h00, 1);
		chk("current", {3'h0, got[0]}, {3'h0, fa(11'h001)});
		rd(TYPE_EXTRA, 3'h0, 1'b1, 8'h3e, 3);
		for (int i = 0; i < 3; i++) begin
			chk("identification_page", {3'h0, got[i]}, {3'h0, fi(4'(14 + i))});
		end
		chk("count", cnt, 11'h001);
		rd(TYPE_ARRAY, 3'h0, 1'b0, 8'h00, 1);
		chk("current", {3'h0, got[0]}, {3'h0, fa(11'h001)});
		rd(TYPE_EXTRA, 3'h0, 1'b1, 8'hb0, 17);
		for (int i = 0; i < 17; i++) begin
			chk("serial", {3'h0, got[i]}, {3'h0, SN[127 - 8 * (i % 16) -: 8]});
		end
		for (int p = 0; p < 2; p++) begin
			prot <= p[0];
			rd(TYPE_EXTRA, 3'h5, 1'b1, 8'hd5, 2);
			chk("protect", {3'h0, got[0]}, {10'h0, p[0]});
			chk("protect rpt", {3'h0, got[1]}, {10'h0, p[0]});
		end
		prot <= 1'b0;
		// both the id space and the lock space codes must reach the lock check
		for (int k = 0; k < 4; k++) begin
			locked <= k[0];
			wr3({1'b0, k[1], 6'h04}, 8'h5a);
			chk("lock ack", {10'h0, nak}, {10'h0, k[0]});
			i_mst.start();
			i_mst.stop();
		end
		i_mst.start();
		i_mst.wr8(8'hc1, nak);
		chk("bad type", {10'h0, nak}, 11'h001);
		i_mst.stop();
		wr3(8'h80, 8'h00);
		chk("serial wr", {10'h0, nak}, 11'h001);
		i_mst.stop();
		end_sim();
	end
endmodule
`default_nettype wire
